// File: inc/cpi_cfg.svh
// Purpose: constants of the camera protector two-wire register block
// Assumes: included by its bare name
// Notes: offsets are register pointer values carried in the pointer byte
`ifndef CPI_CFG_SVH
`define CPI_CFG_SVH

// register pointers
`define CPI_PTR_MASK 8'h00
`define CPI_PTR_CFG 8'h01
`define CPI_PTR_ID 8'h02
`define CPI_PTR_SUPPLY_FAULT_STATUS 8'h03
`define CPI_PTR_CHANNEL12_FAULT_STATUS 8'h04
`define CPI_PTR_STAT3 8'h05
`define CPI_PTR_CONVERSION_RESULT_1 8'h06
`define CPI_PTR_CONVERSION_RESULT_2 8'h07
`define CPI_PTR_CONVERSION_RESULT_3 8'h08
`define CPI_PTR_CONVERSION_RESULT_4 8'h09

// reset values
`define CPI_MASK_RST 8'h00
`define CPI_CFG_RST 8'h1F
`define CPI_STAT_RST 8'h00
`define CPI_ADC_RST 8'h00
// identity value, arbitrary
`define CPI_ID_RST 8'h05

// target address: fixed prefix, factory bits, strap bit
`define CPI_ADDR_PREFIX 4'h5
`define CPI_FACTORY_RST 2'h0

// interrupt_mask fields
`define CPI_M_SELFCK 7
`define CPI_M_CONV 6
`define CPI_M_THERM 5
`define CPI_M_LOGIC 4
`define CPI_M_CAM 3
`define CPI_M_OC 2
`define CPI_M_OV 1
`define CPI_M_UV 0

// channel_control fields
`define CPI_C_LATCH 4
`define CPI_C_CONV_LSB 5

// supply_fault_status fields
`define CPI_S_ISET 5
`define CPI_S_CONV 4
`define CPI_S_INOV 3
`define CPI_S_INUV 2
`define CPI_S_LOV 1
`define CPI_S_LUV 0

// timing: core period and fastest serial clock period, in ns
`define CPI_CORE_NS 100
`define CPI_SCL_MIN_NS 1000
`define CPI_SCL_CYC (`CPI_SCL_MIN_NS / `CPI_CORE_NS)

`endif

// File: inc/cpi_pkg.sv
// Purpose: types of the camera protector two-wire register block
// Assumes: nothing
// Notes: constants live in cpi_cfg.svh
package cpi_pkg;

  // serial engine states
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_ADDR,
    LK_PTR,
    LK_WDATA,
    LK_RDATA,
    LK_IGNORE
  } cpi_link_st_t;

  // live fault levels from the analog front end
  typedef struct packed {
    logic iset;
    logic input_overvolt;
    logic input_undervolt;
    logic logic_overvolt;
    logic logic_undervolt;
    logic [3:0] thermal;
    logic [3:0] overcurrent;
    logic [3:0] overvolt;
    logic [3:0] undervolt;
  } cpi_fault_t;

  // four conversion results, channel 1 in the low byte
  typedef logic [3:0][7:0] cpi_conv_t;

endpackage

// File: logic/cpi_i2c_regs.sv
// Purpose: two-wire target and register bank of a camera power protector
// Assumes: serial clock from the controller, at most 1 MHz
// Notes: serial engine runs on scl_i, registers on core_clk_i
`timescale 1ns/1ps
`include "cpi_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Function
// RULE_01 - stop ends transfer, unless in start pulse
// RULE_02 - never hold the clock line low
// RULE_03 - general call gets no acknowledge
// RULE_04 - first byte: seven address bits, direction
// RULE_05 - address 0101, factory bits, strap bit
// RULE_06 - drive data low through ninth clock
// RULE_07 - write: address, pointer, data, stop
// RULE_08 - read: pointer write, restart, one byte
// RULE_09 - controller retries on missing acknowledge
// RULE_10 - serial access works with chip-on low
// RULE_11 - chip-on rise turns enabled channels on
// RULE_12 - chip-on low: faults hold, clear on read
// RULE_13 - chip-on low: results hold, no clear
// RULE_14 - diagnostics update only with chip-on high
// RULE_15 - alert low on any unmasked status bit
// RULE_16 - ten registers, control resets to 1F
// RULE_17 - mask bit one blocks its fault group
// RULE_18 - two mask bits for supply flags
// RULE_19 - self-check sets overvoltage flags
// RULE_20 - latch mode: hold until read or live
// RULE_21 - channel on needs chip-on and enable
// RULE_22 - correct at serial clock up to 1MHz
// RULE_23 - read-only writes ignored, unmapped reads zero
// RULE_24 - pointer stays put after data byte
module cpi_i2c_regs #(
  parameter logic [1:0] FACTORY_BITS = `CPI_FACTORY_RST, // address bits
  parameter logic [7:0] ID_VALUE = `CPI_ID_RST // arbitrary identity
) (
  input wire logic core_clk_i, // core clock
  input wire logic reset_n_i, // async reset, low
  input wire logic cke_i, // core clock enable
  input wire logic scl_i, // serial clock
  input wire logic sda_i, // serial data in
  output logic sda_o, // serial data out
  output logic sda_oe_o, // serial data drive
  input wire logic addr_strap_i, // address strap pin
  input wire logic chip_on_i, // chip-on pin
  input wire cpi_pkg::cpi_fault_t fault_i, // live faults
  input wire logic conv_valid_i, // conversion done pulse
  input wire cpi_pkg::cpi_conv_t conv_data_i, // results
  output logic [3:0] chan_on_o, // channel switch on
  output logic [2:0] conv_cfg_o, // converter mode
  output logic conv_start_o, // start conversion pulse
  output logic alert_n_o, // alert level, low
  output logic alert_oe_o // alert drive
);

  ////////////////////////////////////////////////////////////////////////
  // link domain: start and stop seen on data line edges

  logic start_q;
  logic stop_q;
  logic lk_stseen_q;
  logic lk_spseen_q;
  logic start_new;

  // start toggles; sampled half a bit later, so it is settled by then
  always_ff @(negedge sda_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      start_q <= 1'b0;
    else if (scl_i)
      start_q <= ~start_q;
  end

  // a stop in the same high pulse as a start is not taken
  always_ff @(posedge sda_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      stop_q <= 1'b0;
    else if (scl_i && start_q == lk_stseen_q) // RULE_01
      stop_q <= ~stop_q;
  end

  assign start_new = start_q ^ lk_stseen_q;

  ////////////////////////////////////////////////////////////////////////
  // link domain: receive and sequence on the rising clock

  cpi_pkg::cpi_link_st_t lk_st_q;
  logic [3:0] lk_cnt_q;
  logic [7:0] lk_sh_q;
  logic [7:0] lk_ptr_q;
  logic [7:0] lk_wd_q;
  logic lk_wr_tgl_q;
  logic lk_rd_tgl_q;
  logic strap_m_q;
  logic strap_s_q;
  logic [7:0] sh_nx;
  logic [6:0] dev_addr;
  logic hit;
  logic hit_nx;
  logic [7:0] rd_hold_q;

  // strap is static; synchronised on the serial clock it serves
  always_ff @(posedge scl_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      strap_m_q <= 1'b0;
      strap_s_q <= 1'b0;
    end
    else
    begin
      strap_m_q <= addr_strap_i;
      strap_s_q <= strap_m_q;
    end
  end

  assign dev_addr = {`CPI_ADDR_PREFIX, FACTORY_BITS, strap_s_q}; // RULE_05
  assign sh_nx = {lk_sh_q[6:0], sda_i};
  // all-zero byte never matches since the prefix is not zero
  assign hit = (lk_sh_q[7:1] == dev_addr); // RULE_03 RULE_04
  assign hit_nx = (sh_nx[7:1] == dev_addr);

  // byte engine: bits counted 1..8, count 8 marks the ack slot
  always_ff @(posedge scl_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lk_st_q <= cpi_pkg::LK_IDLE;
      lk_cnt_q <= 4'h0;
      lk_sh_q <= 8'h00;
      lk_ptr_q <= 8'h00;
      lk_wd_q <= 8'h00;
      lk_wr_tgl_q <= 1'b0;
      lk_rd_tgl_q <= 1'b0;
      lk_stseen_q <= 1'b0;
      lk_spseen_q <= 1'b0;
    end
    else if (start_new)
    begin
      // first address bit arrives on this edge
      lk_stseen_q <= start_q;
      lk_spseen_q <= stop_q;
      lk_st_q <= cpi_pkg::LK_ADDR;
      lk_cnt_q <= 4'h1;
      lk_sh_q <= {7'h00, sda_i};
    end
    else if (stop_q != lk_spseen_q)
    begin
      lk_spseen_q <= stop_q; // RULE_01
      lk_st_q <= cpi_pkg::LK_IDLE;
      lk_cnt_q <= 4'h0;
    end
    else
    begin
      case (lk_st_q)
        cpi_pkg::LK_IDLE, cpi_pkg::LK_IGNORE:
          lk_cnt_q <= 4'h0;
        cpi_pkg::LK_RDATA:
        begin
          if (lk_cnt_q == 4'h8)
          begin
            lk_cnt_q <= 4'h0;
            // not acknowledged: controller is done reading
            if (sda_i)
              lk_st_q <= cpi_pkg::LK_IGNORE; // RULE_08
          end
          else
            lk_cnt_q <= lk_cnt_q + 4'h1;
        end
        default:
        begin
          if (lk_cnt_q != 4'h8)
          begin
            lk_sh_q <= sh_nx;
            lk_cnt_q <= lk_cnt_q + 4'h1;
            // ask the core for a snapshot early, it needs a few cycles
            if (lk_st_q == cpi_pkg::LK_ADDR && lk_cnt_q == 4'h7 &&
                hit_nx && sh_nx[0])
              lk_rd_tgl_q <= ~lk_rd_tgl_q; // RULE_08 RULE_22
          end
          else
          begin
            lk_cnt_q <= 4'h0;
            case (lk_st_q)
              cpi_pkg::LK_ADDR:
                if (!hit)
                  lk_st_q <= cpi_pkg::LK_IGNORE; // RULE_03
                else if (lk_sh_q[0])
                  lk_st_q <= cpi_pkg::LK_RDATA; // RULE_04
                else
                  lk_st_q <= cpi_pkg::LK_PTR;
              cpi_pkg::LK_PTR:
              begin
                lk_ptr_q <= lk_sh_q; // RULE_07
                lk_st_q <= cpi_pkg::LK_WDATA;
              end
              default:
              begin
                // pointer kept: later bytes rewrite the same register
                lk_wd_q <= lk_sh_q; // RULE_24
                lk_wr_tgl_q <= ~lk_wr_tgl_q; // RULE_07
              end
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: data line drive on the falling clock

  logic lk_oe_q;
  logic [7:0] lk_tx_q;

  // only the data line is ever driven; the clock is an input only
  always_ff @(negedge scl_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lk_oe_q <= 1'b0;
      lk_tx_q <= 8'h00;
    end
    else if (start_new)
      lk_oe_q <= 1'b0;
    else
    begin
      case (lk_st_q)
        cpi_pkg::LK_ADDR:
          lk_oe_q <= (lk_cnt_q == 4'h8) && hit; // RULE_06 RULE_03
        cpi_pkg::LK_PTR, cpi_pkg::LK_WDATA:
          lk_oe_q <= (lk_cnt_q == 4'h8); // RULE_06 RULE_23
        cpi_pkg::LK_RDATA:
        begin
          if (lk_cnt_q == 4'h0)
          begin
            lk_tx_q <= {rd_hold_q[6:0], 1'b0};
            lk_oe_q <= ~rd_hold_q[7];
          end
          else if (lk_cnt_q != 4'h8)
          begin
            lk_tx_q <= {lk_tx_q[6:0], 1'b0};
            lk_oe_q <= ~lk_tx_q[7];
          end
          else
            lk_oe_q <= 1'b0; // controller's ack slot
        end
        default:
          lk_oe_q <= 1'b0;
      endcase
    end
  end

  assign sda_o = 1'b0; // open drain: only pulls low
  assign sda_oe_o = lk_oe_q; // RULE_02 RULE_06

  ////////////////////////////////////////////////////////////////////////
  // core domain: crossings

  logic en_m_q;
  logic en_s_q;
  logic [2:0] wr_sy_q;
  logic [2:0] rd_sy_q;
  logic wr_ev;
  logic rd_ev;

  // chip-on and the two request toggles pass two flops first
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      en_m_q <= 1'b0;
      en_s_q <= 1'b0;
      wr_sy_q <= 3'h0;
      rd_sy_q <= 3'h0;
    end
    else if (cke_i)
    begin
      en_m_q <= chip_on_i;
      en_s_q <= en_m_q;
      wr_sy_q <= {wr_sy_q[1:0], lk_wr_tgl_q};
      rd_sy_q <= {rd_sy_q[1:0], lk_rd_tgl_q};
    end
  end

  // pointer and data are stable long before the toggle lands
  assign wr_ev = cke_i && (wr_sy_q[2] ^ wr_sy_q[1]);
  assign rd_ev = cke_i && (rd_sy_q[2] ^ rd_sy_q[1]);

  ////////////////////////////////////////////////////////////////////////
  // core domain: writable registers and channels

  logic [7:0] mask_q;
  logic [7:0] cfg_q;
  logic [3:0] chan_q;

  // registers work whatever chip-on does
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mask_q <= `CPI_MASK_RST; // RULE_16
      cfg_q <= `CPI_CFG_RST; // RULE_16
    end
    else if (wr_ev)
    begin
      if (lk_ptr_q == `CPI_PTR_MASK)
        mask_q <= lk_wd_q; // RULE_10
      else if (lk_ptr_q == `CPI_PTR_CFG)
        cfg_q <= lk_wd_q;
      // other pointers: acknowledged, no effect
    end
  end

  // switches follow chip-on and enable bits; fall turns all off
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      chan_q <= 4'h0;
    else if (cke_i)
      chan_q <= en_s_q ? cfg_q[3:0] : 4'h0; // RULE_11 RULE_21
  end

  assign chan_on_o = chan_q;
  assign conv_cfg_o = cfg_q[7:`CPI_C_CONV_LSB];

  ////////////////////////////////////////////////////////////////////////
  // core domain: status and conversion registers

  logic selfck;
  logic [15:0] ch_live;
  logic [7:0] s1_live;
  logic [7:0] supply_fault_status_q;
  logic [15:0] chs_q;
  logic [15:0] chs_clr;
  logic [7:0] s1_clr;
  logic acc_clr;
  logic latch_live;
  logic [7:0] adc_q [4];
  logic [3:0] ts_v;
  logic [3:0] oc_v;
  logic [3:0] ov_v;
  logic [3:0] uv_v;

  // comparator self-check only with every channel disabled
  assign selfck = mask_q[`CPI_M_SELFCK] && cfg_q[3:0] == 4'h0; // RULE_19
  assign latch_live = cfg_q[`CPI_C_LATCH];

  // per-channel nibble {thermal, overcurrent, overvolt, undervolt}
  for (genvar i = 0; i < 4; i++)
  begin : g_ch
    assign ch_live[4*i+3 -: 4] = {fault_i.thermal[i],
      fault_i.overcurrent[i], fault_i.overvolt[i] | selfck,
      fault_i.undervolt[i]}; // RULE_19
    assign ts_v[i] = chs_q[4*i+3];
    assign oc_v[i] = chs_q[4*i+2];
    assign ov_v[i] = chs_q[4*i+1];
    assign uv_v[i] = chs_q[4*i];
  end

  assign s1_live = {2'h0, fault_i.iset, 1'b0,
    fault_i.input_overvolt | selfck, fault_i.input_undervolt,
    fault_i.logic_overvolt, fault_i.logic_undervolt};

  // read clears; conversion flag is cleared by reading result one
  assign s1_clr = {8{rd_ev && lk_ptr_q == `CPI_PTR_SUPPLY_FAULT_STATUS}};
  assign chs_clr = {{8{rd_ev && lk_ptr_q == `CPI_PTR_STAT3}},
    {8{rd_ev && lk_ptr_q == `CPI_PTR_CHANNEL12_FAULT_STATUS}}};
  assign acc_clr = rd_ev && lk_ptr_q == `CPI_PTR_CONVERSION_RESULT_1;

  // new faults win over a read clear in the same cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      supply_fault_status_q <= `CPI_STAT_RST;
      chs_q <= {2{`CPI_STAT_RST}};
    end
    else if (cke_i)
    begin
      if (en_s_q && latch_live)
      begin
        supply_fault_status_q[7:5] <= s1_live[7:5]; // RULE_20
        supply_fault_status_q[3:0] <= s1_live[3:0];
        chs_q <= ch_live;
      end
      else if (en_s_q)
      begin
        supply_fault_status_q[7:5] <= (supply_fault_status_q[7:5] & ~s1_clr[7:5]) | s1_live[7:5];
        supply_fault_status_q[3:0] <= (supply_fault_status_q[3:0] & ~s1_clr[3:0]) | s1_live[3:0];
        chs_q <= (chs_q & ~chs_clr) | ch_live; // RULE_20 RULE_14
      end
      else
      begin
        // chip-on low: hold, but a read still clears
        supply_fault_status_q[7:5] <= supply_fault_status_q[7:5] & ~s1_clr[7:5]; // RULE_12
        supply_fault_status_q[3:0] <= supply_fault_status_q[3:0] & ~s1_clr[3:0];
        chs_q <= chs_q & ~chs_clr; // RULE_12
      end
      if (en_s_q && conv_valid_i)
        supply_fault_status_q[`CPI_S_CONV] <= 1'b1; // RULE_14
      else if (acc_clr)
        supply_fault_status_q[`CPI_S_CONV] <= 1'b0;
    end
  end

  // results load only while chip-on is high and are never read-cleared
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      adc_q <= '{default: `CPI_ADC_RST};
    else if (cke_i && en_s_q && conv_valid_i)
    begin
      for (int k = 0; k < 4; k++)
        adc_q[k] <= conv_data_i[k]; // RULE_13 RULE_14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core domain: read snapshot and alert

  logic [7:0] rd_mux;
  logic conv_start_q;
  logic alert_d;
  logic alert_q;

  // unmapped pointers read as zero
  always_comb
  begin
    case (lk_ptr_q)
      `CPI_PTR_MASK: rd_mux = mask_q;
      `CPI_PTR_CFG: rd_mux = cfg_q;
      `CPI_PTR_ID: rd_mux = ID_VALUE;
      `CPI_PTR_SUPPLY_FAULT_STATUS: rd_mux = supply_fault_status_q;
      `CPI_PTR_CHANNEL12_FAULT_STATUS: rd_mux = chs_q[7:0];
      `CPI_PTR_STAT3: rd_mux = chs_q[15:8];
      `CPI_PTR_CONVERSION_RESULT_1: rd_mux = adc_q[0];
      `CPI_PTR_CONVERSION_RESULT_2: rd_mux = adc_q[1];
      `CPI_PTR_CONVERSION_RESULT_3: rd_mux = adc_q[2];
      `CPI_PTR_CONVERSION_RESULT_4: rd_mux = adc_q[3];
      default: rd_mux = 8'h00; // RULE_23
    endcase
  end

  // snapshot holds still while the link shifts it out
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_hold_q <= 8'h00;
      conv_start_q <= 1'b0;
    end
    else if (cke_i)
    begin
      if (rd_ev)
        rd_hold_q <= rd_mux; // RULE_08 RULE_16
      conv_start_q <= acc_clr;
    end
  end

  assign conv_start_o = conv_start_q;

  // supply groups have their own two mask bits; range flag has none
  assign alert_d =
    (supply_fault_status_q[`CPI_S_CONV] & ~mask_q[`CPI_M_CONV]) |
    ((|ts_v) & ~mask_q[`CPI_M_THERM]) |
    ((supply_fault_status_q[`CPI_S_LOV] | supply_fault_status_q[`CPI_S_LUV]) &
      ~mask_q[`CPI_M_LOGIC]) | // RULE_18
    ((supply_fault_status_q[`CPI_S_INOV] | supply_fault_status_q[`CPI_S_INUV]) &
      ~mask_q[`CPI_M_CAM]) | // RULE_18
    ((|oc_v) & ~mask_q[`CPI_M_OC]) |
    ((|ov_v) & ~mask_q[`CPI_M_OV]) |
    ((|uv_v) & ~mask_q[`CPI_M_UV]) | // RULE_17
    supply_fault_status_q[`CPI_S_ISET];

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alert_q <= 1'b0;
    else if (cke_i)
      alert_q <= alert_d; // RULE_15
  end

  assign alert_n_o = 1'b0;
  assign alert_oe_o = alert_q; // RULE_15

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence en_rise_s;
    cke_i && en_s_q && !$past(en_s_q);
  endsequence

  chan_rise_a: assert property ( // RULE_11
    en_rise_s |=> chan_q == $past(cfg_q[3:0]))
    else $error("channels not on after chip-on rise");

  chan_off_a: assert property ( // RULE_21
    (cke_i && !en_s_q) |=> chan_q == 4'h0)
    else $error("channel on with chip-on low");

  adc_hold_a: assert property ( // RULE_13
    (cke_i && !en_s_q) |=> $stable(adc_q[0]) && $stable(adc_q[3]))
    else $error("result changed with chip-on low");

  stat_hold_a: assert property ( // RULE_14
    (cke_i && !en_s_q && !rd_ev) |=> $stable(chs_q))
    else $error("status changed with chip-on low");

  rd_clear_a: assert property ( // RULE_12
    (rd_ev && !en_s_q && lk_ptr_q == `CPI_PTR_CHANNEL12_FAULT_STATUS)
      |=> chs_q[7:0] == 8'h00)
    else $error("status not cleared by read");

  self_check_a: assert property ( // RULE_19
    (cke_i && en_s_q && selfck) |=>
      supply_fault_status_q[`CPI_S_INOV] && (&ov_v))
    else $error("self-check flags not set");

  alert_unmask_a: assert property ( // RULE_15
    (cke_i && supply_fault_status_q[`CPI_S_LUV] && !mask_q[`CPI_M_LOGIC])
      |=> alert_oe_o)
    else $error("unmasked flag gave no alert");

  alert_mask_a: assert property ( // RULE_17
    (cke_i && (&mask_q[6:0]) && !supply_fault_status_q[`CPI_S_ISET])
      |=> !alert_oe_o)
    else $error("masked group reached alert");

  ro_write_a: assert property ( // RULE_23
    (wr_ev && lk_ptr_q > `CPI_PTR_CFG) |=>
      $stable(mask_q) && $stable(cfg_q))
    else $error("read-only write took effect");

  ack_drive_a: assert property (@(posedge scl_i) // RULE_06
    disable iff (!reset_n_i)
    (lk_st_q == cpi_pkg::LK_ADDR && lk_cnt_q == 4'h8 && hit &&
      !start_new) |-> lk_oe_q)
    else $error("address not acknowledged");

  gc_quiet_a: assert property (@(posedge scl_i) // RULE_03
    disable iff (!reset_n_i)
    lk_st_q == cpi_pkg::LK_IGNORE |-> !lk_oe_q)
    else $error("data driven in ignored transfer");

endmodule // cpi_i2c_regs

// File: bench/cpi_ctl_model.sv
// Purpose: two-wire bus controller model
// Assumes: bench resolves the data line with a pull-up
// Notes: runs at the 1 MHz ceiling; slower only lengthens the run
`timescale 1ns/1ps

module cpi_ctl_model (
  output logic scl_o, // serial clock
  output logic sda_low_o, // pulls data low
  input wire logic sda_i // resolved data line
);
  localparam int QT = 250; // quarter bit at 1 MHz

  // bus idle: both lines released
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // start when stop is low, else stop; a start leaves the clock low
  task automatic cond(input logic stop);
    sda_low_o = stop;
    #QT;
    scl_o = 1'b1;
    #QT;
    sda_low_o = !stop;
    #QT;
    if (!stop)
      scl_o = 1'b0;
    #QT;
  endtask

  // one bit; data moving while clock is high reads as unknown
  task automatic bit_x(input logic b, output logic s);
    sda_low_o = !b;
    #QT;
    scl_o = 1'b1;
    #QT;
    s = sda_i;
    #QT;
    if (sda_i !== s)
      s = 1'bx;
    scl_o = 1'b0;
    #QT;
  endtask

  // byte out, msb first, then the acknowledge slot
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], s);
    bit_x(1'b1, ack);
    ack = !ack;
  endtask

  // byte in; a nack ends the read
  task automatic rx(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(1'b1, s);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // register write: address, pointer, data, stop
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
    input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    cond(1'b0);
    tx({a, 1'b0}, k0);
    tx(p, k1);
    tx(d, k2);
    cond(1'b1);
    ok = k0 & k1 & k2;
  endtask

  // register read: pointer write, repeated start, one byte
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
    output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    cond(1'b0);
    tx({a, 1'b0}, k0);
    tx(p, k1);
    cond(1'b0);
    tx({a, 1'b1}, k2);
    rx(d);
    cond(1'b1);
    ok = k0 & k1 & k2;
  endtask
endmodule // cpi_ctl_model

// File: bench/cpi_i2c_regs_tb_top.sv
// Purpose: self-checking bench of the protector register block
// Assumes: controller model drives the serial lines
// Notes: expectations come from the register map, not the design
`timescale 1ns/1ps

module cpi_i2c_regs_tb_top;
  localparam logic [7:0] IDV = 8'h5A; // arbitrary identity value
  localparam logic [7:0] RST [11] = '{8'h00, 8'h1F, IDV, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // one fault per mask group, its pointer and status byte
  localparam logic [20:0] FV [6] = '{21'h2, 21'h40, 21'h800, 21'h40000,
    21'h10000, 21'h1000};
  localparam logic [7:0] FP [6] = '{8'h04, 8'h05, 8'h05, 8'h03, 8'h03,
    8'h04};
  localparam logic [7:0] FE [6] = '{8'h10, 8'h02, 8'h40, 8'h04, 8'h01,
    8'h08};

  logic core_clk_i, reset_n_i, cke_i, addr_strap_i, chip_on_i;
  logic conv_valid_i, scl, sda_oe, ctl_low, alert_oe;
  logic [3:0] chan_on;
  logic [2:0] conv_cfg;
  logic conv_start, sda_v, alert_v;
  cpi_pkg::cpi_fault_t fault_i;
  cpi_pkg::cpi_conv_t conv_data_i;
  logic [6:0] adr = 7'h28;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int starts = 0;
  wire sda_w;

  // open-drain data line with pull-up
  assign sda_w = !(sda_oe | ctl_low);

  cpi_i2c_regs #(.ID_VALUE(IDV)) DUT (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cke_i(cke_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_v), .sda_oe_o(sda_oe),
    .addr_strap_i(addr_strap_i), .chip_on_i(chip_on_i),
    .fault_i(fault_i), .conv_valid_i(conv_valid_i),
    .conv_data_i(conv_data_i), .chan_on_o(chan_on),
    .conv_cfg_o(conv_cfg), .conv_start_o(conv_start),
    .alert_n_o(alert_v), .alert_oe_o(alert_oe)
  );

  cpi_ctl_model u_ctl (
    .scl_o(scl), .sda_low_o(ctl_low), .sda_i(sda_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // core clock, 100 ns
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = !core_clk_i;
  end

  // start pulses, counted away from their launch edge
  always @(negedge core_clk_i)
    if (conv_start)
      starts++;

  // hang guard, well above the expected run
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // inputs move 10 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #10;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_ctl.rd(adr, p, d, ok);
    chk({7'h0, ok}, 8'h01);
    chk(d, e);
  endtask

  task automatic wreg(input logic [7:0] p, input logic [7:0] d,
    input logic e);
    logic ok;
    u_ctl.wr(adr, p, d, ok);
    chk({7'h0, ok}, {7'h0, e});
  endtask

  task automatic pulse(input logic [20:0] f);
    fault_i = cpi_pkg::cpi_fault_t'(f);
    cyc(3);
    fault_i = '0;
    cyc(5);
  endtask

  task automatic conv(input cpi_pkg::cpi_conv_t d);
    conv_data_i = d;
    conv_valid_i = 1'b1;
    cyc(1);
    conv_valid_i = 1'b0;
    cyc(4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic k;
    reset_n_i = 1'b0;
    cke_i = 1'b1;
    addr_strap_i = 1'b0;
    chip_on_i = 1'b0;
    conv_valid_i = 1'b0;
    fault_i = '0;
    conv_data_i = '0;
    cyc(4);
    reset_n_i = 1'b1;
    cyc(2);
    for (int i = 0; i < 11; i++)
      rchk(8'(i), RST[i]);
    chk({4'h0, chan_on}, 8'h00);
    // strap moves the address; foreign ones are ignored
    addr_strap_i = 1'b1;
    adr = 7'h29;
    wreg(8'h00, 8'h25, 1'b1);
    adr = 7'h00;
    wreg(8'h00, 8'hFF, 1'b0);
    adr = 7'h28;
    wreg(8'h00, 8'hFF, 1'b0);
    adr = 7'h29;
    rchk(8'h00, 8'h25);
    addr_strap_i = 1'b0;
    adr = 7'h28;
    wreg(8'h00, 8'h00, 1'b1);
    wreg(8'h02, 8'hFF, 1'b1);
    wreg(8'h0C, 8'hFF, 1'b1);
    rchk(8'h02, IDV);
    // stop straight after the address byte
    u_ctl.cond(1'b0);
    u_ctl.tx({adr, 1'b0}, k);
    chk({7'h0, k}, 8'h01);
    u_ctl.cond(1'b1);
    // bits clocked after the stop must find the target idle
    u_ctl.tx(8'hFF, k);
    chk({7'h0, k}, 8'h00);
    rchk(8'h01, 8'h1F);
    // channel gating by chip-on and enable bits
    chip_on_i = 1'b1;
    cyc(5);
    chk({4'h0, chan_on}, 8'h0F);
    wreg(8'h01, 8'hA5, 1'b1);
    cyc(2);
    chk({4'h0, chan_on}, 8'h05);
    chk({5'h0, conv_cfg}, 8'h05);
    // clock enable low freezes the channels
    cke_i = 1'b0;
    chip_on_i = 1'b0;
    cyc(5);
    chk({4'h0, chan_on}, 8'h05);
    cke_i = 1'b1;
    cyc(5);
    chk({4'h0, chan_on}, 8'h00);
    chip_on_i = 1'b1;
    cyc(5);
    chk({4'h0, chan_on}, 8'h05);
    // every fault group open then blocked, latched until read
    for (int g = 0; g < 6; g++)
      for (int m = 0; m < 2; m++)
      begin
        wreg(8'h00, m ? (8'h01 << g) : 8'h00, 1'b1);
        pulse(FV[g]);
        chk({7'h0, alert_oe}, {7'h0, !m});
        rchk(FP[g], FE[g]);
        rchk(FP[g], 8'h00);
      end
    // all groups blocked at once; channel flags stay latched
    wreg(8'h00, 8'h7F, 1'b1);
    pulse(21'h0FFFF);
    chk({7'h0, alert_oe}, 8'h00);
    rchk(8'h04, 8'hFF);
    rchk(8'h05, 8'hFF);
    // results and done flag; only a read of result one clears the flag
    wreg(8'h00, 8'h00, 1'b1);
    conv({8'h44, 8'h33, 8'h22, 8'h11});
    chk({7'h0, alert_oe}, 8'h01);
    rchk(8'h03, 8'h10);
    rchk(8'h03, 8'h10);
    for (int i = 0; i < 4; i++)
      rchk(8'(6 + i), 8'(8'h11 * (i + 1)));
    rchk(8'h03, 8'h00);
    // live mode follows the fault
    wreg(8'h01, 8'h15, 1'b1);
    cyc(1);
    fault_i = cpi_pkg::cpi_fault_t'(FV[5]);
    cyc(4);
    rchk(8'h04, 8'h08);
    chk({7'h0, alert_oe}, 8'h01);
    fault_i = '0;
    cyc(4);
    chk({7'h0, alert_oe}, 8'h00);
    rchk(8'h04, 8'h00);
    // chip-on low: hold, status clears on read, results do not
    wreg(8'h01, 8'h05, 1'b1);
    pulse(FV[1]);
    chip_on_i = 1'b0;
    cyc(4);
    pulse(FV[0]);
    conv('1);
    rchk(8'h05, 8'h02);
    rchk(8'h05, 8'h00);
    rchk(8'h04, 8'h00);
    rchk(8'h06, 8'h11);
    rchk(8'h06, 8'h11);
    // overvoltage self-check with all channels disabled
    chip_on_i = 1'b1;
    wreg(8'h01, 8'h00, 1'b1);
    wreg(8'h00, 8'h80, 1'b1);
    rchk(8'h03, 8'h08);
    rchk(8'h04, 8'h22);
    rchk(8'h05, 8'h22);
    // one converter start per read of result one
    chk(8'(starts), 8'h04);
    // open-drain value pins only ever pull low
    chk({6'h0, sda_v, alert_v}, 8'h00);
    end_of_test();
  end
endmodule // cpi_i2c_regs_tb_top
